// ### chsr_core.sv
// module: host-facing strobes, read acknowledge and ready line of the card
//
// What this block does
// - in I/O mode assert read acknowledge only while selected and answering I/O read.
// - memory mode leaves acknowledge idle and ignores I/O read and write strobes.
// - while I/O read strobe is low in I/O operation, drive read data.
// - I/O write strobe pulse loads bus data into the addressed register.
// - write data is captured on the rising, trailing edge of the write strobe.
// - disk-native mode treats I/O read and write strobes as in I/O mode, except that read acknowledge stays idle.
// - memory mode output enable returns common memory, info structure, config data.
// - in I/O mode output enable serves only info structure and config reads.
// - memory mode ready line high when ready, low when busy.
// - after power-up or reset ready line stays low until processing ends.
// - powered up with reset held open or asserted, ready line stays high.
// - outside disk-native mode, high enable selects odd byte; low enable picks byte by address bit zero.
// - disk-native register accesses, low-enable-only reads: low eight lines; high enable alone outside disk-native mode: high eight; others all sixteen.
`timescale 1ns/100ps
module chsr_core #(
  parameter int unsigned BUSY_CYCLES = chsr_pkg::BUSY_CYCLES
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  // host pins, asynchronous to clk_i
  input wire logic io_read_strobe_n_i,
  input wire logic io_write_strobe_n_i,
  input wire logic output_enable_n_i,
  input wire logic disk_mode_select_n_i,
  input wire logic [1:0] byte_lane_enables_n_i,
  input wire logic addr0_i,
  input wire logic attr_select_n_i,
  input wire logic card_reset_pin_i,
  input wire logic [15:0] host_data_i,
  // device configuration and status
  input wire logic io_configured_i,
  input wire logic io_addr_hit_i,
  input wire logic task_file_sel_i,
  input wire logic card_busy_i,
  input wire logic reset_request_i,
  input wire logic reset_held_from_power_i,
  // internal data sources
  input wire logic [15:0] io_read_data_i,
  input wire logic [15:0] mem_read_data_i,
  input wire logic [15:0] attr_read_data_i,
  // outputs to host pins
  output logic read_response_ack_n_o,
  output logic [15:0] card_data_o,
  output logic [1:0] card_data_oe_n_o,
  output logic card_ready_line_o,
  // internal write side
  output logic io_write_pulse_o,
  output logic [15:0] io_write_data_o,
  output logic [1:0] io_write_lanes_o,
  output chsr_pkg::chsr_mode_type mode_o
);

  // ------------------------------------------------------------
  // pin synchronisation
  // ------------------------------------------------------------
  localparam int unsigned PIN_W = 8;
  localparam logic [PIN_W-1:0] PIN_RST = 8'h3F;
  logic [PIN_W-1:0] pins_s;
  logic [15:0] data_s;
  logic io_read_strobe_n_n_s;
  logic io_write_strobe_n_n_s;
  logic oe_n_s;
  logic disk_sel_n_s;
  logic [1:0] ce_n_s;
  logic a0_s;
  logic reg_n_s;

  chsr_sync #(.WIDTH(PIN_W), .RST_VAL(PIN_RST)) u_pin_sync (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .d_i({addr0_i, attr_select_n_i, byte_lane_enables_n_i, disk_mode_select_n_i,
          output_enable_n_i, io_write_strobe_n_i, io_read_strobe_n_i}),
    .q_o(pins_s)
  );

  chsr_sync #(.WIDTH(chsr_pkg::DATA_W), .RST_VAL(chsr_pkg::DATA_RST)) u_data_sync (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .d_i(host_data_i),
    .q_o(data_s)
  );

  assign io_read_strobe_n_n_s = pins_s[0];
  assign io_write_strobe_n_n_s = pins_s[1];
  assign oe_n_s = pins_s[2];
  assign disk_sel_n_s = pins_s[3];
  assign ce_n_s = pins_s[5:4];
  assign reg_n_s = pins_s[6];
  assign a0_s = pins_s[7];

  // ------------------------------------------------------------
  // mode selection
  // ------------------------------------------------------------
  // a grounded select pin means disk-native mode
  chsr_pkg::chsr_mode_type mode;
  logic io_like;
  logic selected;
  assign mode = !disk_sel_n_s ? chsr_pkg::CHSR_MODE_DISK :
                (io_configured_i ? chsr_pkg::CHSR_MODE_IO : chsr_pkg::CHSR_MODE_MEM);
  assign io_like = (mode != chsr_pkg::CHSR_MODE_MEM);
  assign selected = (ce_n_s != 2'b11);
  assign mode_o = mode;

  // ------------------------------------------------------------
  // byte lane steering
  // ------------------------------------------------------------
  // word bytes addressed: bit 0 the even byte, bit 1 the odd byte
  function automatic logic [1:0] lanes_f(input logic [1:0] ce_n, input logic a0,
                                         input logic disk);
    logic [1:0] l;
    l = 2'b00;
    if (disk) begin
      l = 2'b11;
    end else if (ce_n == 2'b00) begin
      l = 2'b11;
    end else if (ce_n == 2'b10) begin
      l = a0 ? 2'b10 : 2'b01;
    end else if (ce_n == 2'b01) begin
      l = 2'b10;
    end
    return l;
  endfunction

  // with only the low enable, the odd byte travels on d[7:0] in both directions
  function automatic logic [15:0] steer_f(input logic [15:0] d, input logic [1:0] ce_n,
                                          input logic a0, input logic to_host);
    logic [15:0] r;
    r = d;
    if (ce_n == 2'b10 && a0) begin
      r = to_host ? {d[15:8], d[15:8]} : {d[7:0], d[7:0]};
    end
    return r;
  endfunction

  logic [1:0] lanes;
  logic [1:0] rd_lanes;
  logic disk_task;
  assign disk_task = (mode == chsr_pkg::CHSR_MODE_DISK) && task_file_sel_i;
  assign lanes = lanes_f(ce_n_s, a0_s, mode == chsr_pkg::CHSR_MODE_DISK);
  assign rd_lanes = (disk_task || ce_n_s == 2'b10) ? 2'b01 : lanes;

  // ------------------------------------------------------------
  // read decode
  // ------------------------------------------------------------
  // output enable in I/O mode only reaches attribute space; in disk-native mode it reaches nothing
  logic io_rd;
  logic oe_mem_rd;
  logic oe_attr_rd;
  logic rd_any;
  assign io_rd = io_like && selected && !io_read_strobe_n_n_s && io_addr_hit_i;
  assign oe_mem_rd = (mode == chsr_pkg::CHSR_MODE_MEM) && selected && !oe_n_s && reg_n_s;
  assign oe_attr_rd = (mode != chsr_pkg::CHSR_MODE_DISK) && selected && !oe_n_s
                      && !reg_n_s;
  assign rd_any = io_rd || oe_mem_rd || oe_attr_rd;

  logic [15:0] rd_src;
  assign rd_src = io_rd ? io_read_data_i : (oe_mem_rd ? mem_read_data_i : attr_read_data_i);

  logic [15:0] data_q;
  logic [1:0] oe_n_q;
  logic ack_n_q;

  // registered drive; released one edge after strobe or select goes away
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      data_q <= chsr_pkg::DATA_RST;
      oe_n_q <= 2'b11;
      ack_n_q <= 1'b1;
    end else begin
      data_q <= steer_f(rd_src, ce_n_s, a0_s, 1'b1);
      oe_n_q <= rd_any ? ~rd_lanes : 2'b11;
      ack_n_q <= !(io_rd && mode == chsr_pkg::CHSR_MODE_IO);
    end
  end

  assign card_data_o = data_q;
  assign card_data_oe_n_o = oe_n_q;
  assign read_response_ack_n_o = ack_n_q;

  // ------------------------------------------------------------
  // write capture
  // ------------------------------------------------------------
  // the strobe is sampled one cycle back so its rising edge can be seen
  logic io_write_strobe_n_n_q;
  logic wr_sel_q;
  logic [15:0] wr_data_q;
  logic [1:0] wr_lanes_q;
  logic wr_pulse_q;
  logic wr_rise;
  assign wr_rise = !io_write_strobe_n_n_q && io_write_strobe_n_n_s;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      io_write_strobe_n_n_q <= 1'b1;
      wr_sel_q <= 1'b0;
      wr_data_q <= chsr_pkg::DATA_RST;
      wr_lanes_q <= 2'b00;
      wr_pulse_q <= 1'b0;
    end else begin
      io_write_strobe_n_n_q <= io_write_strobe_n_n_s;
      // data tracks the bus while strobe is low; last low sample is kept
      if (!io_write_strobe_n_n_s) begin
        wr_sel_q <= io_like && selected && io_addr_hit_i;
        wr_data_q <= steer_f(data_s, ce_n_s, a0_s, 1'b0);
        wr_lanes_q <= disk_task ? 2'b01 : lanes;
      end
      wr_pulse_q <= wr_rise && wr_sel_q && io_like;
    end
  end

  assign io_write_pulse_o = wr_pulse_q;
  assign io_write_data_o = wr_data_q;
  assign io_write_lanes_o = wr_lanes_q;

  // ------------------------------------------------------------
  // ready line
  // ------------------------------------------------------------
  // the busy count restarts on every reset request; a held reset pin disables busy
  logic [chsr_pkg::BUSY_CNT_W-1:0] busy_cnt_q;
  logic [chsr_pkg::BUSY_CNT_W-1:0] busy_cnt_d;
  logic init_busy;
  logic rdy_q;
  logic no_busy;
  localparam logic [chsr_pkg::BUSY_CNT_W-1:0] BUSY_LOAD = BUSY_CYCLES[chsr_pkg::BUSY_CNT_W-1:0];
  assign init_busy = (busy_cnt_q != '0);
  assign no_busy = reset_held_from_power_i || card_reset_pin_i;
  assign busy_cnt_d = reset_request_i ? BUSY_LOAD :
                      (init_busy ? busy_cnt_q - 1'b1 : busy_cnt_q);

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      busy_cnt_q <= BUSY_LOAD;
      rdy_q <= 1'b0;
    end else begin
      busy_cnt_q <= busy_cnt_d;
      rdy_q <= no_busy || (!init_busy && !reset_request_i && !card_busy_i);
    end
  end

  assign card_ready_line_o = rdy_q;

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  sequence s_wr_low;
    !io_write_strobe_n_n_s && wr_sel_q;
  endsequence
  sequence s_wr_high;
    io_write_strobe_n_n_s && io_like;
  endsequence

  AST_ACK_CAUSE: assert property (
    !read_response_ack_n_o |-> $past(io_rd) && $past(mode) == chsr_pkg::CHSR_MODE_IO)
    else $error("acknowledge without I/O read");
  AST_MEM_QUIET: assert property (
    mode == chsr_pkg::CHSR_MODE_MEM |=> read_response_ack_n_o && !io_write_pulse_o)
    else $error("memory mode reacted to I/O strobe");
  AST_DISK_ACK: assert property (
    mode == chsr_pkg::CHSR_MODE_DISK |=> read_response_ack_n_o)
    else $error("acknowledge active in disk mode");
  AST_IO_DRIVE: assert property (
    io_rd |=> card_data_oe_n_o != 2'b11 && card_data_o == $past(steer_f(io_read_data_i,
      ce_n_s, a0_s, 1'b1)))
    else $error("I/O read data not driven");
  AST_WR_EDGE: assert property (
    s_wr_low ##1 s_wr_high |=> io_write_pulse_o)
    else $error("write not taken on trailing edge");
  AST_WR_NOFALL: assert property (
    $fell(io_write_strobe_n_n_s) |=> !io_write_pulse_o)
    else $error("write taken on falling edge");
  AST_OE_IO: assert property (
    mode == chsr_pkg::CHSR_MODE_IO && !oe_n_s && reg_n_s && io_read_strobe_n_n_s |=> card_data_oe_n_o == 2'b11)
    else $error("output enable served common memory in I/O mode");
  AST_BUSY_HOLD: assert property (
    reset_request_i && !no_busy |=> !card_ready_line_o [*2])
    else $error("ready during reset processing");
  AST_NO_BUSY: assert property (
    no_busy |=> card_ready_line_o)
    else $error("busy shown with reset held");
  AST_RELEASE: assert property (
    !rd_any |=> card_data_oe_n_o == 2'b11 && read_response_ack_n_o)
    else $error("bus not released");

endmodule

// ### chsr_pkg.sv
// package: shared constants for the card host strobe and ready block
package chsr_pkg;

  // ------------------------------------------------------------
  // interface modes
  // ------------------------------------------------------------
  typedef enum logic [1:0] {
    CHSR_MODE_MEM,
    CHSR_MODE_IO,
    CHSR_MODE_DISK
  } chsr_mode_type;

  // ------------------------------------------------------------
  // timing
  // ------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS = 10;
  // default time for internal power-up or reset processing, in ns
  localparam int unsigned BUSY_TIME_NS = 1000;
  localparam int unsigned BUSY_CYCLES = (BUSY_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned BUSY_CNT_W = 16;

  // ------------------------------------------------------------
  // bus widths and reset values
  // ------------------------------------------------------------
  localparam int unsigned DATA_W = 16;
  localparam int unsigned BYTE_W = 8;
  localparam logic [15:0] DATA_RST = 16'h0000;

endpackage

// ### chsr_sync.sv
// module: two flip-flop synchroniser for a bundle of pin levels
`timescale 1ns/100ps
module chsr_sync #(
  parameter int unsigned WIDTH = 1,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic [WIDTH-1:0] d_i,
  output logic [WIDTH-1:0] q_o
);

  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] sync_q;

  // first stage is read only by the second stage
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      meta_q <= RST_VAL;
      sync_q <= RST_VAL;
    end else begin
      meta_q <= d_i;
      sync_q <= meta_q;
    end
  end

  assign q_o = sync_q;

endmodule

// ### chsr_host_model.sv
// host socket adapter model that drives the card strobes
`timescale 1ns/100ps
module chsr_host_model (
  input wire logic clk_i,
  input wire logic ready_i,
  input wire logic ack_n_i,
  input wire logic [15:0] data_i,
  input wire logic [1:0] oe_n_i,
  output logic io_read_strobe_n_o,
  output logic io_write_strobe_n_o,
  output logic output_enable_n_o,
  output logic disk_mode_select_n_o,
  output logic [1:0] byte_lane_enables_n_o,
  output logic addr0_o,
  output logic attr_select_n_o,
  output logic [15:0] data_o,
  output logic seen_ack_n_o,
  output logic [15:0] seen_data_o,
  output logic [1:0] seen_oe_n_o
);
  // ----------------------------------------
  // idle levels: word access, no strobe
  // ----------------------------------------
  initial begin
    io_read_strobe_n_o = 1'b1;
    io_write_strobe_n_o = 1'b1;
    output_enable_n_o = 1'b1;
    disk_mode_select_n_o = 1'b1;
    byte_lane_enables_n_o = 2'h0;
    addr0_o = 1'b0;
    attr_select_n_o = 1'b1;
    data_o = 16'h0000;
  end
  // wait up to 60 cycles for the card to report ready, then access anyway
  task automatic wait_ready();
    for (int n = 0; n < 60 && ready_i !== 1'b1; n++) @(negedge clk_i);
    @(negedge clk_i);
  endtask
  // grounding the select pin picks the disk-native mode
  task automatic set_disk(input logic sel_n);
    @(negedge clk_i);
    disk_mode_select_n_o = sel_n;
  endtask
  // byte enables and address bit zero change only between cycles
  task automatic set_lanes(input logic [1:0] ce_n, input logic a);
    @(negedge clk_i);
    byte_lane_enables_n_o = ce_n;
    addr0_o = a;
  endtask
  // read with either strobe; ack, data and enables are sampled after five cycles, whatever the ack
  task automatic read_cycle(input logic use_oe, input logic attr_n);
    wait_ready();
    attr_select_n_o = attr_n;
    if (use_oe) output_enable_n_o = 1'b0;
    else io_read_strobe_n_o = 1'b0;
    repeat (5) @(negedge clk_i);
    seen_ack_n_o = ack_n_i;
    seen_data_o = data_i;
    seen_oe_n_o = oe_n_i;
    io_read_strobe_n_o = 1'b1;
    output_enable_n_o = 1'b1;
    attr_select_n_o = 1'b1;
    repeat (5) @(negedge clk_i);
  endtask
  // write pulse; the bus is released with inverted data after the rise
  task automatic write_cycle(input logic [15:0] d);
    wait_ready();
    attr_select_n_o = 1'b0;
    data_o = d;
    io_write_strobe_n_o = 1'b0;
    repeat (5) @(negedge clk_i);
    io_write_strobe_n_o = 1'b1;
    attr_select_n_o = 1'b1;
    data_o = ~d;
    repeat (5) @(negedge clk_i);
  endtask
endmodule

// ### card_host_strobes_ready_bench.sv
// self-checking bench for the card strobe and ready block
`timescale 1ns/100ps
module card_host_strobes_ready_bench;
  logic clk = 1'b0, rst_n = 1'b0, io_cfg = 1'b1, hit = 1'b1, busy = 1'b0, rst_req = 1'b0;
  logic held = 1'b0, pin_rst = 1'b0, tfs = 1'b0;
  logic [15:0] io_d = 16'h3C5A, mem_d = 16'h9E17, attr_d = 16'h00F1;
  logic rd_n, wr_n, oe_n, dsel_n, a0, attr_n, ack_n, ready, wpulse, s_ack;
  logic [1:0] lanes_n, coe_n, wlanes, s_oe;
  logic [15:0] hdata, cdata, wdata, s_data;
  chsr_pkg::chsr_mode_type mode;
  int fail_count = 0, comparisons = 0, pulses = 0;
  localparam int BUSY = 4;
  // ----------------------------------------
  // clock and write pulse counter
  // ----------------------------------------
  initial forever #5 clk = ~clk;
  always @(posedge clk) if (wpulse === 1'b1) pulses <= pulses + 1;
  chsr_core #(.BUSY_CYCLES(BUSY)) dut (.clk_i(clk), .rst_n_i(rst_n),
    .io_read_strobe_n_i(rd_n), .io_write_strobe_n_i(wr_n), .output_enable_n_i(oe_n),
    .disk_mode_select_n_i(dsel_n), .byte_lane_enables_n_i(lanes_n), .addr0_i(a0),
    .attr_select_n_i(attr_n), .card_reset_pin_i(pin_rst), .host_data_i(hdata),
    .io_configured_i(io_cfg), .io_addr_hit_i(hit), .task_file_sel_i(tfs),
    .card_busy_i(busy), .reset_request_i(rst_req), .reset_held_from_power_i(held),
    .io_read_data_i(io_d), .mem_read_data_i(mem_d), .attr_read_data_i(attr_d),
    .read_response_ack_n_o(ack_n), .card_data_o(cdata), .card_data_oe_n_o(coe_n),
    .card_ready_line_o(ready), .io_write_pulse_o(wpulse), .io_write_data_o(wdata),
    .io_write_lanes_o(wlanes), .mode_o(mode));
  chsr_host_model host (.clk_i(clk), .ready_i(ready), .ack_n_i(ack_n), .data_i(cdata),
    .oe_n_i(coe_n), .io_read_strobe_n_o(rd_n), .io_write_strobe_n_o(wr_n),
    .output_enable_n_o(oe_n), .disk_mode_select_n_o(dsel_n),
    .byte_lane_enables_n_o(lanes_n), .addr0_o(a0), .attr_select_n_o(attr_n),
    .data_o(hdata), .seen_ack_n_o(s_ack), .seen_data_o(s_data), .seen_oe_n_o(s_oe));
  // ----------------------------------------
  // compare and verdict
  // ----------------------------------------
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    comparisons++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD %s exp %h got %h", what, exp, got);
    end
  endtask
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // read through the model and judge ack and lanes, and data when both lanes are driven
  task automatic rd(input logic oe, input logic at, input logic xa, input logic [1:0] xo,
                    input logic [15:0] xd);
    host.read_cycle(oe, at);
    chk("ack_seen", {15'h0, xa}, {15'h0, s_ack});
    chk("oe_seen", {14'h0, xo}, {14'h0, s_oe});
    if (xo == 2'h0) chk("data_seen", xd, s_data);
  endtask
  task automatic t_reset();
    chk("ready_low_after_release", 16'h0, {15'h0, ready});
    repeat (BUSY + 4) @(negedge clk);
    chk("ready_high_after_busy", 16'h1, {15'h0, ready});
    $display("done reset");
  endtask
  task automatic t_io();
    rd(1'b0, 1'b0, 1'b0, 2'h0, io_d);
    chk("ack_released", 16'h1, {15'h0, ack_n});
    chk("oe_released", 16'h3, {14'h0, coe_n});
    hit = 1'b0;
    rd(1'b0, 1'b0, 1'b1, 2'h3, io_d);
    hit = 1'b1;
    rd(1'b1, 1'b0, 1'b1, 2'h0, attr_d);
    rd(1'b1, 1'b1, 1'b1, 2'h3, mem_d);
    host.set_lanes(2'h2, 1'b1);
    rd(1'b0, 1'b0, 1'b0, 2'h2, io_d);
    chk("odd_on_low_lane", {8'h0, io_d[15:8]}, {8'h0, s_data[7:0]});
    t_write(16'h0077, 1, 2'h2, 16'h7777);
    host.set_lanes(2'h1, 1'b0);
    rd(1'b0, 1'b0, 1'b0, 2'h1, io_d);
    chk("odd_on_high_lane", {8'h0, io_d[15:8]}, {8'h0, s_data[15:8]});
    host.set_lanes(2'h0, 1'b0);
    $display("done io read");
  endtask
  task automatic t_write(input logic [15:0] d, input int xp, input logic [1:0] xl,
                         input logic [15:0] xd);
    int base;
    base = pulses;
    fork
      host.write_cycle(d);
      begin
        repeat (4) @(negedge clk);
        chk("no_pulse_while_low", 16'h0, 16'(pulses - base));
      end
    join
    chk("write_pulses", 16'(xp), 16'(pulses - base));
    if (xp == 1) chk("write_data", xd, wdata);
    if (xp == 1) chk("write_lanes", {14'h0, xl}, {14'h0, wlanes});
    $display("done write %h", d);
  endtask
  task automatic t_mem();
    io_cfg = 1'b0;
    rd(1'b0, 1'b1, 1'b1, 2'h3, io_d);
    t_write(16'hBEEF, 0, 2'h0, 16'h0000);
    rd(1'b1, 1'b1, 1'b1, 2'h0, mem_d);
    rd(1'b1, 1'b0, 1'b1, 2'h0, attr_d);
    io_cfg = 1'b1;
    $display("done memory mode");
  endtask
  task automatic t_disk();
    host.set_disk(1'b0);
    @(negedge clk);
    @(negedge clk);
    chk("mode_disk", 16'(chsr_pkg::CHSR_MODE_DISK), 16'(mode));
    rd(1'b0, 1'b1, 1'b1, 2'h0, io_d);
    t_write(16'h1234, 1, 2'h3, 16'h1234);
    tfs = 1'b1;
    rd(1'b0, 1'b1, 1'b1, 2'h2, io_d);
    chk("task_file_low_byte", {8'h0, io_d[7:0]}, {8'h0, s_data[7:0]});
    t_write(16'h00C4, 1, 2'h1, 16'h00C4);
    tfs = 1'b0;
    host.set_disk(1'b1);
    $display("done disk mode");
  endtask
  task automatic t_ready();
    busy = 1'b1;
    repeat (3) @(negedge clk);
    chk("ready_busy", 16'h0, {15'h0, ready});
    busy = 1'b0;
    repeat (3) @(negedge clk);
    chk("ready_free", 16'h1, {15'h0, ready});
    rst_req = 1'b1;
    @(negedge clk);
    rst_req = 1'b0;
    chk("ready_low_on_request", 16'h0, {15'h0, ready});
    repeat (BUSY + 3) @(negedge clk);
    chk("ready_back", 16'h1, {15'h0, ready});
    held = 1'b1;
    rst_n = 1'b0;
    repeat (2) @(negedge clk);
    rst_n = 1'b1;
    repeat (2) @(negedge clk);
    chk("ready_held_high", 16'h1, {15'h0, ready});
    held = 1'b0;
    pin_rst = 1'b1;
    busy = 1'b1;
    repeat (2) @(negedge clk);
    chk("ready_pin_reset_high", 16'h1, {15'h0, ready});
    pin_rst = 1'b0;
    busy = 1'b0;
    $display("done ready");
  endtask
  // ----------------------------------------
  // main sequence and watchdog
  // ----------------------------------------
  initial begin
    repeat (8) @(negedge clk);
    rst_n = 1'b1;
    @(negedge clk);
    t_reset();
    t_io();
    t_write(16'hA5C3, 1, 2'h3, 16'hA5C3);
    t_mem();
    t_disk();
    t_ready();
    give_verdict();
  end
  initial begin
    #200000;
    fail_count++;
    $display("watchdog expired");
    give_verdict();
  end
endmodule
